/* File: common/low_power_card_detect_pkg.sv */
// Purpose: constants, register map and states of the card detect sequencer
// Assumes: 200 MHz system clock, APB register access with 32-bit data
// Notes: register indices are word indices; byte address is four times
package lpdl_pkg;
    // clock and unit times
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned FIELD_STEP_US = 8;
    localparam int unsigned AUX_STEP_US = 5;
    localparam int unsigned FIELD_STEP_CYC = FIELD_STEP_US * CLK_MHZ;
    localparam int unsigned AUX_STEP_CYC = AUX_STEP_US * CLK_MHZ;
    localparam int unsigned SUB_W = 12;

    // register indices and address width
    localparam logic [7:0] IDX_REF_SET = 8'h34;
    localparam logic [7:0] IDX_FIELD_TIME = 8'h36;
    localparam logic [7:0] IDX_THRESHOLD = 8'h37;
    localparam logic [7:0] IDX_SRC_AUX = 8'h38;
    localparam logic [7:0] IDX_AUX_PRE = 8'h39;
    localparam logic [7:0] IDX_AUX_POST = 8'h3a;
    localparam logic [7:0] IDX_MODE_SWITCH = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [7:0] IDX_GAIN_REF = 8'h42;
    localparam int unsigned ADDR_W = 12;

    // field layout
    localparam int unsigned GEAR_W = 4;
    localparam int unsigned GAIN_W = 10;
    localparam int unsigned STBY_W = 20;
    localparam int unsigned GO_BIT = 31;
    localparam int unsigned PWR_CTL_BIT = 30;
    localparam int unsigned GREF_LSB = 16;
    localparam int unsigned ST_DET_BIT = 0;
    localparam int unsigned ST_ACT_BIT = 1;
    localparam int unsigned ST_AUX1_BIT = 2;
    localparam int unsigned ST_AUX2_BIT = 3;
    localparam int unsigned ST_STATE_LSB = 8;
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned BIT_AUX1_WAKE = 2;
    localparam int unsigned BIT_AUX2_DET = 3;
    localparam int unsigned BIT_AUX1_SUPPLY = 4;
    localparam logic [1:0] SRC_AUTO = 2'h0;
    localparam logic [1:0] SRC_SELF = 2'h1;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_CALIB = 7'b000_0010,
        ST_STANDBY = 7'b000_0100,
        ST_AUX_PRE = 7'b000_1000,
        ST_FIELD_CMD = 7'b001_0000,
        ST_FIELD_ON = 7'b010_0000,
        ST_AUX_POST = 7'b100_0000
    } lpdl_state_e;
endpackage

/* File: logic/low_power_card_detect_seq.sv */
// Purpose: low-power card detect loop sequencer with APB register slave
// Assumes: all inputs synchronous to CLK_SYS; slow oscillator is a level
// Notes: one wait state on every APB access; outputs are flip-flops
//
// Functional notes
// - slow oscillator ticks drive a wake-up counter whose expiry ends standby.
// - host starts the loop with a mode switch carrying standby duration.
// - every iteration starts in standby, timed only by the wake-up counter.
// - detection turns the field on for the set time, then compares gain.
// - detection raises the interrupt; host settings are not restored.
// - no detection means no interrupt and a return to standby, after the aux one post delay when aux one is enabled.
// - loop stops on detection, reset, host select, or external field.
// - reset stops the loop and clears all configuration.
// - without power control the field uses type A 106 kbit/s settings.
// - with power control, issue field-on command after standby, not before the calibration field; timer starts after it.
// - field-on time is one byte times 8 microseconds.
// - detect when reference minus current gain exceeds the threshold byte.
// - reference setting is 16 bits; gear in 3:0, 15:4 reserved.
// - source bits 1:0 pick auto calibration or the gain reference register.
// - control bit 2 lets aux output one change level before field-on.
// - control bit 3 drives aux output two on card detection.
// - control bit 4 drives aux output one on wake-up from standby.
// - aux one high to field-on delay is one byte times 5 microseconds.
// - field-off to aux one low delay is one byte times 5 microseconds.
// - aux one rises before the field and falls after field-off.
`timescale 1ns/10ps
`default_nettype none
module lpdl_seq
    import lpdl_pkg::*;
#(
    parameter int unsigned FIELD_STEP = FIELD_STEP_CYC,
    parameter int unsigned AUX_STEP = AUX_STEP_CYC
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLOW_WAKE_OSC,
    input wire logic [GAIN_W-1:0] GAIN_LEVEL,
    input wire logic HOST_SEL_N,
    input wire logic EXT_FIELD_DET,
    input wire logic FIELD_CMD_DONE,
    output logic FIELD_ON,
    output logic FIELD_TYPE_A,
    output logic FIELD_ON_CMD,
    output logic [GEAR_W-1:0] GAIN_GEAR,
    output logic CARD_DETECT_IRQ,
    output logic FIRST_AUX_OUT,
    output logic SECOND_AUX_OUT,
    output logic LOOP_ACTIVE
);

    function automatic logic at_idx(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
        at_idx = (a == {2'b00, idx, 2'b00});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers
    lpdl_state_e state_ff, nxt_state;
    logic [GEAR_W-1:0] ref_gear_ff;
    logic [7:0] fot_ff, thr_ff, ctl_ff, pre_ff, post_ff;
    logic [STBY_W-1:0] stby_dur_ff, stby_cnt_ff;
    logic pwr_ctl_ff, act_ff;
    logic [GEAR_W-1:0] gref_gear_ff;
    logic [GAIN_W-1:0] gref_lvl_ff, ref_ff;
    logic [7:0] units_ff;
    logic [SUB_W-1:0] sub_ff;
    logic step_aux_ff;
    logic osc_q_ff;
    logic irq_ff, aux1_ff, aux2_ff, field_ff, type_a_ff, cmd_ff, hit_ff;
    logic [GEAR_W-1:0] gear_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; write commits at the edge where pready is sampled high
    wire acc = PSEL & PENABLE;
    wire wr_en = acc & PWRITE & pready_ff;
    wire rd_cap = acc & ~pready_ff;
    wire sel_ref = at_idx(PADDR, IDX_REF_SET);
    wire sel_fot = at_idx(PADDR, IDX_FIELD_TIME);
    wire sel_thr = at_idx(PADDR, IDX_THRESHOLD);
    wire sel_ctl = at_idx(PADDR, IDX_SRC_AUX);
    wire sel_pre = at_idx(PADDR, IDX_AUX_PRE);
    wire sel_post = at_idx(PADDR, IDX_AUX_POST);
    wire sel_mode = at_idx(PADDR, IDX_MODE_SWITCH);
    wire sel_stat = at_idx(PADDR, IDX_STATUS);
    wire sel_gref = at_idx(PADDR, IDX_GAIN_REF);
    wire mapped = sel_ref | sel_fot | sel_thr | sel_ctl | sel_pre |
                  sel_post | sel_mode | sel_stat | sel_gref;
    wire idle = (state_ff == ST_IDLE);
    wire start = wr_en & sel_mode & PWDATA[GO_BIT] & idle;
    wire irq_clr = wr_en & sel_stat & PWDATA[ST_DET_BIT];

    // read mux; reserved bits read as zero
    logic [31:0] rd_val;
    always_comb begin
        rd_val = WORD_ZERO;
        if (sel_ref) begin
            rd_val[GEAR_W-1:0] = ref_gear_ff;
        end else if (sel_fot) begin
            rd_val[7:0] = fot_ff;
        end else if (sel_thr) begin
            rd_val[7:0] = thr_ff;
        end else if (sel_ctl) begin
            rd_val[7:0] = ctl_ff;
        end else if (sel_pre) begin
            rd_val[7:0] = pre_ff;
        end else if (sel_post) begin
            rd_val[7:0] = post_ff;
        end else if (sel_mode) begin
            rd_val[STBY_W-1:0] = stby_dur_ff;
            rd_val[PWR_CTL_BIT] = pwr_ctl_ff;
        end else if (sel_stat) begin
            rd_val[ST_DET_BIT] = irq_ff;
            rd_val[ST_ACT_BIT] = ~idle;
            rd_val[ST_AUX1_BIT] = aux1_ff;
            rd_val[ST_AUX2_BIT] = aux2_ff;
            rd_val[ST_STATE_LSB +: 7] = state_ff;
        end else if (sel_gref) begin
            rd_val[GEAR_W-1:0] = gref_gear_ff;
            rd_val[GREF_LSB +: GAIN_W] = gref_lvl_ff;
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= WORD_ZERO;
        end else begin
            pready_ff <= rd_cap;
            pslverr_ff <= rd_cap & ~mapped;
            if (rd_cap) begin
                prdata_ff <= rd_val;
            end
        end
    end

    // configuration; reset clears it all, loop or not
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ref_gear_ff <= '0;
            fot_ff <= BYTE_RST;
            thr_ff <= BYTE_RST;
            ctl_ff <= BYTE_RST;
            pre_ff <= BYTE_RST;
            post_ff <= BYTE_RST;
            stby_dur_ff <= '0;
            pwr_ctl_ff <= 1'b0;
            gref_gear_ff <= '0;
            gref_lvl_ff <= '0;
        end else if (wr_en) begin
            if (sel_ref) ref_gear_ff <= PWDATA[GEAR_W-1:0];
            if (sel_fot) fot_ff <= PWDATA[7:0];
            if (sel_thr) thr_ff <= PWDATA[7:0];
            if (sel_ctl) ctl_ff <= PWDATA[7:0];
            if (sel_pre) pre_ff <= PWDATA[7:0];
            if (sel_post) post_ff <= PWDATA[7:0];
            if (sel_mode && idle) begin
                stby_dur_ff <= PWDATA[STBY_W-1:0];
                pwr_ctl_ff <= PWDATA[PWR_CTL_BIT];
            end
            if (sel_gref) begin
                gref_gear_ff <= PWDATA[GEAR_W-1:0];
                gref_lvl_ff <= PWDATA[GREF_LSB +: GAIN_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer decode
    wire stop = ~idle & (~HOST_SEL_N | EXT_FIELD_DET);
    // go write and standby entry share one edge: take the new word itself
    wire [STBY_W-1:0] stby_load = start ? PWDATA[STBY_W-1:0] : stby_dur_ff;
    wire pwr_now = start ? PWDATA[PWR_CTL_BIT] : pwr_ctl_ff;
    wire slow_tick = SLOW_WAKE_OSC & ~osc_q_ff;
    wire tmr_done = (units_ff == 8'h00);
    wire aux1_en = ctl_ff[BIT_AUX1_WAKE] | ctl_ff[BIT_AUX1_SUPPLY];
    wire src_auto = (ctl_ff[SRC_LSB +: 2] == SRC_AUTO);
    wire src_self = (ctl_ff[SRC_LSB +: 2] == SRC_SELF);
    wire [GAIN_W:0] diff = {1'b0, ref_ff} - {1'b0, GAIN_LEVEL};
    wire hit_now = ~diff[GAIN_W] &&
                   (diff[GAIN_W-1:0] > {2'b00, thr_ff});
    wire meas_end = (state_ff == ST_FIELD_ON) & tmr_done;

    // next state and timer loads
    logic tmr_ld, tmr_aux;
    logic [7:0] tmr_val;
    always_comb begin
        nxt_state = state_ff;
        tmr_ld = 1'b0;
        tmr_aux = 1'b0;
        tmr_val = fot_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start && src_auto) begin
                    nxt_state = ST_CALIB;
                    tmr_ld = 1'b1;
                end else if (start) begin
                    nxt_state = ST_STANDBY;
                end
            end
            ST_CALIB: if (tmr_done) nxt_state = ST_STANDBY;
            ST_STANDBY: begin
                if (stby_cnt_ff == '0 && aux1_en) begin
                    nxt_state = ST_AUX_PRE;
                    tmr_ld = 1'b1;
                    tmr_aux = 1'b1;
                    tmr_val = pre_ff;
                end else if (stby_cnt_ff == '0 && pwr_ctl_ff) begin
                    nxt_state = ST_FIELD_CMD;
                end else if (stby_cnt_ff == '0) begin
                    nxt_state = ST_FIELD_ON;
                    tmr_ld = 1'b1;
                end
            end
            ST_AUX_PRE: begin
                if (tmr_done && pwr_ctl_ff) begin
                    nxt_state = ST_FIELD_CMD;
                end else if (tmr_done) begin
                    nxt_state = ST_FIELD_ON;
                    tmr_ld = 1'b1;
                end
            end
            ST_FIELD_CMD: begin
                if (FIELD_CMD_DONE) begin
                    nxt_state = ST_FIELD_ON;
                    tmr_ld = 1'b1;
                end
            end
            ST_FIELD_ON: begin
                if (tmr_done && aux1_en) begin
                    nxt_state = ST_AUX_POST;
                    tmr_ld = 1'b1;
                    tmr_aux = 1'b1;
                    tmr_val = post_ff;
                end else if (tmr_done && hit_now) begin
                    nxt_state = ST_IDLE;
                end else if (tmr_done) begin
                    nxt_state = ST_STANDBY;
                end
            end
            ST_AUX_POST: begin
                if (tmr_done) nxt_state = hit_ff ? ST_IDLE : ST_STANDBY;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (stop) begin
            nxt_state = ST_IDLE;
            tmr_ld = 1'b0;
        end
    end

    // state, slow tick edge and wake-up counter
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_ff <= ST_IDLE;
            osc_q_ff <= 1'b0;
            stby_cnt_ff <= '0;
            act_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            act_ff <= (nxt_state != ST_IDLE);
            osc_q_ff <= SLOW_WAKE_OSC;
            if (nxt_state == ST_STANDBY && state_ff != ST_STANDBY) begin
                stby_cnt_ff <= stby_load;
            end else if (slow_tick && stby_cnt_ff != '0) begin
                stby_cnt_ff <= stby_cnt_ff - 1'b1;
            end
        end
    end

    // delay timer in 8 us or 5 us units; a zero byte ends at once
    wire [SUB_W-1:0] sub_last = step_aux_ff ? SUB_W'(AUX_STEP - 1) :
                                              SUB_W'(FIELD_STEP - 1);
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            units_ff <= '0;
            sub_ff <= '0;
            step_aux_ff <= 1'b0;
        end else if (tmr_ld) begin
            units_ff <= tmr_val;
            sub_ff <= '0;
            step_aux_ff <= tmr_aux;
        end else if (stop) begin
            units_ff <= '0;
        end else if (!tmr_done) begin
            sub_ff <= (sub_ff == sub_last) ? '0 : sub_ff + 1'b1;
            if (sub_ff == sub_last) units_ff <= units_ff - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference, field and aux outputs
    wire field_nxt = (nxt_state == ST_FIELD_ON) | (nxt_state == ST_CALIB);
    wire aux1_nxt = (nxt_state == ST_AUX_PRE) |
                    ((nxt_state == ST_FIELD_CMD || nxt_state == ST_FIELD_ON ||
                      nxt_state == ST_AUX_POST) & aux1_en);
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ref_ff <= '0;
            gear_ff <= '0;
            field_ff <= 1'b0;
            type_a_ff <= 1'b0;
            cmd_ff <= 1'b0;
            aux1_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else begin
            if (start && src_self) begin
                ref_ff <= gref_lvl_ff;
                gear_ff <= gref_gear_ff;
            end else if (start) begin
                gear_ff <= ref_gear_ff;
            end
            if (state_ff == ST_CALIB && tmr_done) ref_ff <= GAIN_LEVEL;
            field_ff <= field_nxt;
            type_a_ff <= field_nxt & ~pwr_now;
            cmd_ff <= (nxt_state == ST_FIELD_CMD) &&
                      (state_ff != ST_FIELD_CMD);
            aux1_ff <= aux1_nxt;
            if (meas_end) hit_ff <= hit_now;
        end
    end

    // interrupt is held until a status clear or the next start, aux two until the next start; the set wins
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            irq_ff <= 1'b0;
            aux2_ff <= 1'b0;
        end else begin
            if (meas_end && hit_now && !stop) begin
                irq_ff <= 1'b1;
                aux2_ff <= ctl_ff[BIT_AUX2_DET];
            end else begin
                if (irq_clr || start) irq_ff <= 1'b0;
                if (start) aux2_ff <= 1'b0;
            end
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign FIELD_ON = field_ff;
    assign FIELD_TYPE_A = type_a_ff;
    assign FIELD_ON_CMD = cmd_ff;
    assign GAIN_GEAR = gear_ff;
    assign CARD_DETECT_IRQ = irq_ff;
    assign FIRST_AUX_OUT = aux1_ff;
    assign SECOND_AUX_OUT = aux2_ff;
    assign LOOP_ACTIVE = act_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_stby_exit;
        @(posedge CLK_SYS) disable iff (SRST)
        (state_ff == ST_STANDBY && stby_cnt_ff == '0 && !stop)
            |=> (state_ff != ST_STANDBY);
    endproperty
    a_stby_exit: assert property (p_stby_exit)
        else $error("standby did not end at counter zero");

    property p_stby_load;
        @(posedge CLK_SYS) disable iff (SRST)
        (state_ff != ST_STANDBY ##1 state_ff == ST_STANDBY)
            |-> (stby_cnt_ff == stby_dur_ff);
    endproperty
    a_stby_load: assert property (p_stby_load)
        else $error("wake-up counter not loaded on standby entry");

    property p_field_phase;
        @(posedge CLK_SYS) disable iff (SRST)
        FIELD_ON |-> (state_ff == ST_FIELD_ON || state_ff == ST_CALIB);
    endproperty
    a_field_phase: assert property (p_field_phase)
        else $error("field on outside detection");

    property p_irq_hit;
        @(posedge CLK_SYS) disable iff (SRST)
        (meas_end && hit_now && !stop)
            |=> (CARD_DETECT_IRQ && !FIELD_ON && state_ff != ST_STANDBY);
    endproperty
    a_irq_hit: assert property (p_irq_hit)
        else $error("detection raised no interrupt");

    property p_miss;
        @(posedge CLK_SYS) disable iff (SRST)
        (meas_end && !hit_now && !aux1_en && !stop && !CARD_DETECT_IRQ)
            |=> (state_ff == ST_STANDBY && !CARD_DETECT_IRQ);
    endproperty
    a_miss: assert property (p_miss)
        else $error("miss did not return quietly to standby");

    property p_stop;
        @(posedge CLK_SYS) disable iff (SRST)
        stop |=> (state_ff == ST_IDLE) ##1 !FIELD_ON;
    endproperty
    a_stop: assert property (p_stop)
        else $error("loop not stopped");

    property p_reset;
        @(posedge CLK_SYS) SRST |=> (state_ff == ST_IDLE && ctl_ff == BYTE_RST);
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear loop");

    property p_type_a;
        @(posedge CLK_SYS) disable iff (SRST)
        (FIELD_ON && !pwr_ctl_ff && $stable(pwr_ctl_ff)) |-> FIELD_TYPE_A;
    endproperty
    a_type_a: assert property (p_type_a)
        else $error("type A settings missing");

    property p_cmd_wait;
        @(posedge CLK_SYS) disable iff (SRST)
        (state_ff == ST_FIELD_CMD && !FIELD_CMD_DONE && !stop)
            |=> (state_ff == ST_FIELD_CMD && units_ff == '0);
    endproperty
    a_cmd_wait: assert property (p_cmd_wait)
        else $error("field timer ran before command end");

    property p_fot_load;
        @(posedge CLK_SYS) disable iff (SRST)
        (state_ff != ST_FIELD_ON ##1 state_ff == ST_FIELD_ON)
            |-> (units_ff == fot_ff && sub_ff == '0);
    endproperty
    a_fot_load: assert property (p_fot_load)
        else $error("field time not loaded");

    property p_aux_order;
        @(posedge CLK_SYS) disable iff (SRST)
        (state_ff == ST_AUX_PRE || state_ff == ST_AUX_POST) |-> ##1
            (FIRST_AUX_OUT || state_ff == ST_IDLE || state_ff == ST_STANDBY);
    endproperty
    a_aux_order: assert property (p_aux_order)
        else $error("aux one not held around the field");

    c_detect: cover property (@(posedge CLK_SYS) meas_end && hit_now);
    c_miss: cover property (@(posedge CLK_SYS) meas_end && !hit_now);
    c_aux: cover property (@(posedge CLK_SYS) state_ff == ST_AUX_POST);
    c_pwr_ctl: cover property (@(posedge CLK_SYS) FIELD_ON_CMD);
endmodule
`default_nettype wire

/* File: sim/low_power_card_detect_far.sv */
// Purpose: far side model: slow oscillator and field command answer
// Assumes: clocked by the system clock of the bench
// Notes: done is a one-cycle pulse that rises lat plus one cycles after the edge that samples each command
`timescale 1ns/10ps
`default_nettype none
module lpdl_far (
    input wire logic clk,
    input wire logic cmd,
    input wire logic [7:0] lat,
    output logic osc,
    output logic done
);
    int oc = 0;
    int dc = 0;
    // slow oscillator, one rise every 16 cycles; level follows the count
    always @(posedge clk) begin
        oc <= oc + 1;
        osc <= (oc % 16) >= 8;
    end
    // a slow answer exposes a timer that starts too early
    always @(posedge clk) begin
        done <= (cmd !== 1'b1) && (dc == 1);
        if (cmd === 1'b1) dc <= lat + 1;
        else if (dc > 0) dc <= dc - 1;
    end
endmodule
`default_nettype wire

/* File: sim/low_power_card_detect_loop_tb.sv */
// Purpose: self-checking bench for the card detect sequencer
// Assumes: short step parameters keep timed phases brief
// Notes: reads are checked by a monitor against a queue of notes
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, (a), (b)); end end
module low_power_card_detect_loop_tb;
    import lpdl_pkg::*;
    localparam int FS = 4;
    localparam int AS = 3;
    logic clk, srst, psel, penable, pwrite, osc, sel_n, ext, done;
    logic pready, pslverr, f_on, f_a, f_cmd, irq, aux1, aux2, act, ta;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [GAIN_W-1:0] gain;
    logic [GEAR_W-1:0] gear;
    logic [7:0] lat, fot, thr, aon;
    logic [32:0] q[$];
    logic [32:0] e;
    int n_fail = 0;
    int total_checks = 0;
    int fcnt = 0;
    int flen = 0;
    int ncmd = 0;
    int n0;
    lpdl_seq #(.FIELD_STEP(FS), .AUX_STEP(AS)) dut (
        .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SLOW_WAKE_OSC(osc),
        .GAIN_LEVEL(gain), .HOST_SEL_N(sel_n), .EXT_FIELD_DET(ext),
        .FIELD_CMD_DONE(done), .FIELD_ON(f_on), .FIELD_TYPE_A(f_a),
        .FIELD_ON_CMD(f_cmd), .GAIN_GEAR(gear), .CARD_DETECT_IRQ(irq),
        .FIRST_AUX_OUT(aux1), .SECOND_AUX_OUT(aux2), .LOOP_ACTIVE(act));
    lpdl_far far (.clk(clk), .cmd(f_cmd), .lat(lat), .osc(osc),
        .done(done));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    // one transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] i, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ba(i);
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [32:0] x);
        q.push_back(x);
        apb(1'b0, i, 32'h0000_0000);
    endtask
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ///////////////////////////////////////////////////////////////////
    // read monitor takes the oldest note whenever read data appears
    always @(posedge clk) begin
        if (pready === 1'b1 && psel && penable && !pwrite) begin
            e = q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end
    // field watcher: on-time length, type A flag, aux level at field rise
    always @(posedge clk) begin
        if (f_on === 1'b1) begin
            fcnt <= fcnt + 1;
            ta <= f_a;
            if (fcnt == 0) aon <= {7'h00, aux1};
        end else if (fcnt != 0) begin
            flen <= fcnt;
            fcnt <= 0;
        end
        if (f_cmd === 1'b1) ncmd <= ncmd + 1;
    end
    initial begin
        #300000;
        n_fail++;
        summarize();
    end
    ///////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, srst, ext, sel_n} = 6'h05;
        {paddr, pwdata, gain, lat} = '0;
        void'($urandom(32'h8966dfc0));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        // config reads zero after reset, unmapped place is refused
        rd(IDX_FIELD_TIME, 33'h0);
        rd(IDX_SRC_AUX, 33'h0);
        rd(8'h3f, 33'h1_0000_0000);
        fot = 8'($urandom_range(2, 5));
        thr = 8'($urandom_range(16, 64));
        apb(1'b1, IDX_FIELD_TIME, {24'h0, fot});
        apb(1'b1, IDX_THRESHOLD, {24'h0, thr});
        apb(1'b1, IDX_REF_SET, 32'h0000_0003);
        apb(1'b1, IDX_AUX_PRE, 32'h0000_0001);
        apb(1'b1, IDX_AUX_POST, 32'h0000_0002);
        apb(1'b1, IDX_SRC_AUX, 32'h0000_000d);
        apb(1'b1, IDX_GAIN_REF, 32'h0200_0005);
        rd(IDX_FIELD_TIME, {25'h0, fot});
        rd(IDX_THRESHOLD, {25'h0, thr});
        rd(IDX_REF_SET, 33'h3);
        rd(IDX_SRC_AUX, 33'hd);
        // hit by one count over the threshold, reference from register
        gain <= 10'h200 - {2'b00, thr} - 10'h001;
        apb(1'b1, IDX_MODE_SWITCH, 32'h8000_0002);
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        `CHK({irq, f_on, aux1, aux2, ta, gear}, 9'h175)
        `CHK(flen >= fot * FS && flen <= fot * FS + 1, 1'b1)
        `CHK(aon, 8'h01)
        repeat (2 * AS + 4) @(posedge clk);
        `CHK({aux1, act}, 2'b00)
        rd(IDX_STATUS, 33'h109);
        apb(1'b1, IDX_STATUS, 32'h0000_0001);
        rd(IDX_STATUS, 33'h108);
        // misses under power control with a slow command answer
        apb(1'b1, IDX_SRC_AUX, 32'h0000_0000);
        gain <= 10'($urandom_range(128, 1023));
        lat <= 8'h14;
        n0 = ncmd;
        apb(1'b1, IDX_MODE_SWITCH, 32'hc000_0001);
        repeat (800) @(posedge clk);
        `CHK({irq, act, ta, gear}, 7'h23)
        `CHK(ncmd - n0 >= 2, 1'b1)
        sel_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(act, 1'b0)
        sel_n <= 1'b1;
        apb(1'b1, IDX_MODE_SWITCH, 32'h8000_0001);
        repeat (100) @(posedge clk);
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(act, 1'b0)
        ext <= 1'b0;
        // standby lasts whole slow ticks, then reset in mid loop
        apb(1'b1, IDX_SRC_AUX, 32'h0000_0001);
        apb(1'b1, IDX_MODE_SWITCH, 32'h8000_0004);
        repeat (20) @(posedge clk);
        `CHK({act, f_on}, 2'b10)
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK({act, f_on, irq}, 3'b000)
        rd(IDX_FIELD_TIME, 33'h0);
        repeat (4) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
